// File: shared/wdg_pkg.sv
// package: register map, field layout, reset values and timing for the watchdog
package wdg_pkg;

  // clock rates
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned OSC_NOM_HZ = 10000;
  localparam int unsigned CLK_PER_OSC = CLK_HZ / OSC_NOM_HZ;

  // timing counts: time-out in prescaled ticks, grace in low-speed oscillator ticks
  localparam int unsigned TIMEOUT_TICKS = 64;
  localparam int unsigned GRACE_TICKS = 512;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  // watchdog_control field positions
  localparam int unsigned BIT_GENERAL_RUN = 7;
  localparam int unsigned BIT_COUNTER_CLEAR = 6;
  localparam int unsigned BIT_TIMEOUT_FLAG = 5;
  localparam int unsigned BIT_RUN_IN_SLEEP = 4;
  localparam int unsigned BIT_DOG_RESET_FLAG = 3;
  localparam int unsigned BIT_PRESCALE_LO = 0;
  localparam int unsigned PRESCALE_W = 3;

  // config and irq enable field positions
  localparam int unsigned BIT_MODE_CFG_LO = 4;
  localparam int unsigned MODE_CFG_W = 4;
  localparam int unsigned BIT_DOG_IRQ_EN = 0;
  localparam int unsigned BIT_GLOBAL_IRQ_EN = 1;

  // reset values and mode codes
  localparam logic [2:0] PRESCALE_POR = 3'h7;
  localparam logic [3:0] MODE_CFG_POR = 4'hF;
  localparam logic [3:0] MODE_GENERAL = 4'hF;
  localparam logic [3:0] MODE_STOP_IN_SLEEP = 4'h5;

  // timed-access keys
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timed-access unlock states
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_OPEN = 2'b10
  } wdg_key_state_t;

  // AXI4-Lite master-to-slave signals
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } wdg_axil_req_t;

  // AXI4-Lite slave-to-master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } wdg_axil_rsp_t;

  // divider ratio minus one for a prescale code: 1,4,8,...,256
  function automatic logic [7:0] wdg_ratio_m1(input logic [2:0] code);
    logic [8:0] ratio;
    // shift worked out at 4 bits so that code 7 reaches 256
    ratio = (code == 3'h0) ? 9'h001 : (9'h001 << ({1'b0, code} + 4'h1));
    return 8'(ratio - 9'h001);
  endfunction : wdg_ratio_m1

endpackage : wdg_pkg

// File: src/wdg_timer.sv
// watchdog and interval timer with AXI4-Lite register access
//
// Notes on behaviour
// - writing one to counter_clear zeroes the count; writing zero does nothing
// - counter_clear reads one while the clear is pending, zero once done
// - timeout_flag set on overflow; cleared by software, power-on reset or other_reset
// - general mode: run_in_sleep zero stops counting asleep, one keeps counting
// - dog_reset_flag set by watchdog reset, cleared by power-on reset or a software write of zero
// - prescale codes 0..7 divide by 1,4,8,16,32,64,128,256
// - power-on reset sets prescale to 111; other resets keep it
// - time-out after 64 prescaled ticks
// - mode field not all ones means time-out reset timer
// - reset mode value 5 stops counter asleep; other values keep counting
// - reset mode ignores general_run and run_in_sleep
// - reset mode counts from reset release without software action
// - time-out sets flag; interrupt when both enables are set
// - after reset-mode time-out, 512 osc clocks to clear or system reset
// - control register writes accepted only after timed-access unlock
// - counter and prescaler cleared on sleep entry, wake-up, any reset
// - mode field all ones gives general timer under software control
// - general mode: run starts, clear halts; flag set each interval, keeps counting
// - counts in power-down and wakes the core at interval end
// - general_run is bit 7; one enables and starts the counter
// - counter clocked from the 10 kHz oscillator through the divider
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module wdg_timer
  import wdg_pkg::*;
#(
  parameter int unsigned TIMEOUT_TICKS_P = wdg_pkg::TIMEOUT_TICKS,
  parameter int unsigned GRACE_TICKS_P = wdg_pkg::GRACE_TICKS
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire wdg_pkg::wdg_axil_req_t axil_req,
  output wdg_pkg::wdg_axil_rsp_t axil_rsp,
  input wire logic low_speed_osc,
  input wire logic other_reset,
  input wire logic idle_mode,
  input wire logic pdown_mode,
  output logic irq_req,
  output logic wake_req,
  output logic sys_reset_req
);
  import wdg_pkg::*;

  localparam int unsigned CNT_W = $clog2(TIMEOUT_TICKS_P);
  localparam int unsigned GRC_W = $clog2(GRACE_TICKS_P);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_TICKS_P - 1);
  localparam logic [GRC_W-1:0] GRC_LAST = GRC_W'(GRACE_TICKS_P - 1);

  // elaboration checks
  if (TIMEOUT_TICKS_P < 2 || TIMEOUT_TICKS_P > 256)
  begin : g_bad_timeout
    $error("timeout tick count out of range");
  end
  if (GRACE_TICKS_P < 2 || GRACE_TICKS_P > 65536)
  begin : g_bad_grace
    $error("grace tick count out of range");
  end
  if (CLK_PER_OSC < 4)
  begin : g_bad_clock
    $error("system clock too slow to sample the oscillator");
  end

  // bus-side state
  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  wdg_key_state_t key_state_reg;
  wdg_key_state_t key_state_next;

  // block state
  logic general_run_reg;
  logic clear_pending_reg;
  logic timeout_flag_reg;
  logic run_in_sleep_reg;
  logic dog_reset_flag_reg;
  logic [2:0] prescale_reg;
  logic [3:0] mode_cfg_reg;
  logic dog_irq_en_reg;
  logic global_irq_en_reg;
  logic [7:0] presc_cnt_reg;
  logic [CNT_W-1:0] tick_cnt_reg;
  logic grace_active_reg;
  logic [GRC_W-1:0] grace_cnt_reg;
  logic dog_fire_reg;
  logic irq_reg;
  logic wake_reg;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic sleep_d_reg;

  // decoded strobes
  logic do_write;
  logic wr_lane;
  logic wr_mapped;
  logic unlocked;
  logic ctrl_wr;
  logic cfg_wr;
  logic ien_wr;
  logic key_wr;
  logic soft_rst;
  logic osc_tick;
  logic sleeping;
  logic sleep_edge;
  logic general_mode;
  logic counting;
  logic presc_done;
  logic overflow;
  logic rd_take;
  logic [7:0] rd_byte;
  logic rd_mapped;

  // oscillator synchroniser and rising-edge detect
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end
    else
    begin
      osc_s1_reg <= low_speed_osc;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  assign osc_tick = osc_s2_reg & ~osc_s3_reg;

  // sleep tracking for entry and wake-up edges
  assign sleeping = idle_mode | pdown_mode;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sleep_d_reg <= 1'b0;
    else
      sleep_d_reg <= sleeping;
  end
  assign sleep_edge = sleeping ^ sleep_d_reg;

  // any reset other than power-on, including our own
  assign soft_rst = other_reset | dog_fire_reg;

  // write channel capture, either order
  assign axil_rsp.awready = ~aw_held_reg;
  assign axil_rsp.wready = ~w_held_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (axil_req.awvalid && !aw_held_reg)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= axil_req.awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end
    else if (axil_req.wvalid && !w_held_reg)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= axil_req.wdata[7:0];
      w_strb_reg <= axil_req.wstrb[0];
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end

  // write decode; unmapped addresses answer SLVERR
  always_comb
  begin
    wr_mapped = 1'b1;
    case (aw_addr_reg)
      OFS_CONTROL, OFS_KEY, OFS_CONFIG, OFS_IRQ_EN, OFS_COUNT: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  assign wr_lane = do_write & w_strb_reg;
  assign unlocked = key_state_reg == KEY_OPEN;
  assign key_wr = wr_lane & (aw_addr_reg == OFS_KEY);
  assign ctrl_wr = wr_lane & unlocked & (aw_addr_reg == OFS_CONTROL);
  assign cfg_wr = wr_lane & unlocked & (aw_addr_reg == OFS_CONFIG);
  assign ien_wr = wr_lane & (aw_addr_reg == OFS_IRQ_EN);

  // write response
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (axil_req.bready)
      bvalid_reg <= 1'b0;
  end
  assign axil_rsp.bvalid = bvalid_reg;
  assign axil_rsp.bresp = bresp_reg;

  // timed-access unlock sequence; any write after opening closes it
  always_comb
  begin
    key_state_next = key_state_reg;
    if (do_write)
    begin
      case (key_state_reg)
        KEY_IDLE:
          key_state_next = (key_wr && w_data_reg == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
        KEY_GOT_FIRST:
          key_state_next = (key_wr && w_data_reg == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
        KEY_OPEN:
          key_state_next = KEY_IDLE;
        default:
          key_state_next = KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || soft_rst)
      key_state_reg <= KEY_IDLE;
    else
      key_state_reg <= key_state_next;
  end

  // read channel
  assign rd_take = axil_req.arvalid & ~rvalid_reg;
  assign axil_rsp.arready = ~rvalid_reg;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    case (axil_req.araddr)
      OFS_CONTROL:
        rd_byte = {general_run_reg, clear_pending_reg, timeout_flag_reg,
                   run_in_sleep_reg, dog_reset_flag_reg, prescale_reg};
      OFS_KEY:
        rd_byte = {7'h00, unlocked};
      OFS_CONFIG:
        rd_byte = {mode_cfg_reg, 4'h0};
      OFS_IRQ_EN:
        rd_byte = {6'h00, global_irq_en_reg, dog_irq_en_reg};
      OFS_COUNT:
        rd_byte = 8'(tick_cnt_reg);
      default:
        rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (axil_req.rready)
      rvalid_reg <= 1'b0;
  end
  assign axil_rsp.rvalid = rvalid_reg;
  assign axil_rsp.rdata = rdata_reg;
  assign axil_rsp.rresp = rresp_reg;

  // mode configuration, loaded to all ones at power-on
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mode_cfg_reg <= MODE_CFG_POR;
    else if (cfg_wr)
      mode_cfg_reg <= w_data_reg[BIT_MODE_CFG_LO +: MODE_CFG_W];
  end
  assign general_mode = mode_cfg_reg == MODE_GENERAL;

  // interrupt enables
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || soft_rst)
    begin
      dog_irq_en_reg <= 1'b0;
      global_irq_en_reg <= 1'b0;
    end
    else if (ien_wr)
    begin
      dog_irq_en_reg <= w_data_reg[BIT_DOG_IRQ_EN];
      global_irq_en_reg <= w_data_reg[BIT_GLOBAL_IRQ_EN];
    end
  end

  // run controls, writable in either mode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || soft_rst)
    begin
      general_run_reg <= 1'b0;
      run_in_sleep_reg <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      general_run_reg <= w_data_reg[BIT_GENERAL_RUN];
      run_in_sleep_reg <= w_data_reg[BIT_RUN_IN_SLEEP];
    end
  end

  // prescale select survives all but power-on reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      prescale_reg <= PRESCALE_POR;
    else if (ctrl_wr)
      prescale_reg <= w_data_reg[BIT_PRESCALE_LO +: PRESCALE_W];
  end

  // clear request pending until the next oscillator tick; set wins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || soft_rst)
      clear_pending_reg <= 1'b0;
    else if (ctrl_wr && w_data_reg[BIT_COUNTER_CLEAR])
      clear_pending_reg <= 1'b1;
    else if (osc_tick)
      clear_pending_reg <= 1'b0;
  end

  // run condition per mode
  always_comb
  begin
    if (general_mode)
      counting = general_run_reg & (~sleeping | run_in_sleep_reg);
    else
      counting = ~(sleeping & (mode_cfg_reg == MODE_STOP_IN_SLEEP));
  end

  assign presc_done = presc_cnt_reg == wdg_ratio_m1(prescale_reg);
  assign overflow = osc_tick & ~clear_pending_reg & counting & presc_done
                    & (tick_cnt_reg == CNT_LAST);

  // prescaler and tick counter
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || soft_rst || sleep_edge)
    begin
      presc_cnt_reg <= 8'h00;
      tick_cnt_reg <= '0;
    end
    else if (osc_tick)
    begin
      if (clear_pending_reg)
      begin
        presc_cnt_reg <= 8'h00;
        tick_cnt_reg <= '0;
      end
      else if (counting)
      begin
        if (presc_done)
        begin
          presc_cnt_reg <= 8'h00;
          tick_cnt_reg <= overflow ? '0 : tick_cnt_reg + 1'b1;
        end
        else
          presc_cnt_reg <= presc_cnt_reg + 8'h01;
      end
    end
  end

  // time-out flag; hardware sets, software writes clear, set wins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || other_reset)
      timeout_flag_reg <= 1'b0;
    else if (overflow)
      timeout_flag_reg <= 1'b1;
    else if (ctrl_wr)
      timeout_flag_reg <= w_data_reg[BIT_TIMEOUT_FLAG];
  end

  // grace window after a reset-mode time-out
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || soft_rst)
    begin
      grace_active_reg <= 1'b0;
      grace_cnt_reg <= '0;
      dog_fire_reg <= 1'b0;
    end
    else
    begin
      dog_fire_reg <= 1'b0;
      if (clear_pending_reg && osc_tick)
        grace_active_reg <= 1'b0;
      else if (grace_active_reg && osc_tick)
      begin
        if (grace_cnt_reg == GRC_LAST)
        begin
          grace_active_reg <= 1'b0;
          dog_fire_reg <= 1'b1;
        end
        else
          grace_cnt_reg <= grace_cnt_reg + 1'b1;
      end
      else if (overflow && !general_mode && !grace_active_reg)
      begin
        grace_active_reg <= 1'b1;
        grace_cnt_reg <= '0;
      end
    end
  end

  // watchdog reset flag, kept across all but power-on reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      dog_reset_flag_reg <= 1'b0;
    else if (dog_fire_reg)
      dog_reset_flag_reg <= 1'b1;
    else if (ctrl_wr)
      dog_reset_flag_reg <= w_data_reg[BIT_DOG_RESET_FLAG];
  end

  // interrupt level and wake pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= timeout_flag_reg & dog_irq_en_reg & global_irq_en_reg;
      wake_reg <= overflow & sleeping;
    end
  end

  assign irq_req = irq_reg;
  assign wake_req = wake_reg;
  assign sys_reset_req = dog_fire_reg;

endmodule : wdg_timer

// File: bench/wdg_timer_asserts.sv
// port-level concurrent checks for the watchdog timer
`timescale 1ns/1ps
module wdg_timer_asserts
#(
  parameter int unsigned TIMEOUT_TICKS_P = 64,
  parameter int unsigned GRACE_TICKS_P = 512
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire wdg_pkg::wdg_axil_req_t axil_req,
  input wire wdg_pkg::wdg_axil_rsp_t axil_rsp,
  input wire logic low_speed_osc,
  input wire logic other_reset,
  input wire logic idle_mode,
  input wire logic pdown_mode,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic sys_reset_req
);
  import wdg_pkg::*;
  logic rd_bad;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // read address outside the map or not word aligned
  assign rd_bad = (axil_req.araddr[1:0] != 2'h0) || (axil_req.araddr > OFS_COUNT);

  // handshake steps
  sequence s_wr_taken;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  endsequence
  sequence s_rd_taken;
    axil_req.arvalid && axil_rsp.arready;
  endsequence

  // bus answers
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] axil_rsp.bvalid)
    else $error("write answer missing");
  a_aw_busy: assert property (s_wr_taken |=> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write channel ready while busy");
  a_rd_slverr: assert property (s_rd_taken and rd_bad |=> axil_rsp.rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_rd_okay: assert property (s_rd_taken and !rd_bad
    |=> axil_rsp.rvalid && axil_rsp.rresp == RESP_OKAY)
    else $error("mapped read not answered");
  a_b_stands: assert property (axil_rsp.bvalid && !axil_req.bready
    |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
    else $error("write response dropped");
  a_r_stands: assert property (axil_rsp.rvalid && !axil_req.rready
    |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read response dropped");

  // timer outputs
  a_dog_pulse: assert property (sys_reset_req |=> !sys_reset_req ##1 !irq_req)
    else $error("system reset pulse wrong");
  a_irq_reset: assert property (other_reset |-> ##2 !irq_req)
    else $error("interrupt survives reset");
  a_wake_cause: assert property (wake_req |-> $past(idle_mode || pdown_mode) ##1 !wake_req)
    else $error("wake without sleep");
endmodule : wdg_timer_asserts

bind wdg_timer wdg_timer_asserts #(
  .TIMEOUT_TICKS_P(TIMEOUT_TICKS_P),
  .GRACE_TICKS_P(GRACE_TICKS_P)
) u_asserts (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .axil_req(axil_req),
  .axil_rsp(axil_rsp),
  .low_speed_osc(low_speed_osc),
  .other_reset(other_reset),
  .idle_mode(idle_mode),
  .pdown_mode(pdown_mode),
  .irq_req(irq_req),
  .wake_req(wake_req),
  .sys_reset_req(sys_reset_req)
);

// File: bench/wdg_timer_bench.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
module wdg_timer_bench;
  import wdg_pkg::*;
  localparam int TO = 4;
  localparam int GR = 8;
  localparam int HP = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  wdg_axil_req_t axil_req = '0;
  wdg_axil_rsp_t axil_rsp;
  logic low_speed_osc = 1'b0;
  logic other_reset = 1'b0;
  logic idle_mode = 1'b0;
  logic pdown_mode = 1'b0;
  logic irq_req;
  logic wake_req;
  logic sys_reset_req;
  int mismatches = 0;
  int n_checks = 0;
  int osc_cnt = 0;
  int cyc;
  int t;
  logic seen;
  logic [31:0] rv;

  wdg_timer #(.TIMEOUT_TICKS_P(TO), .GRACE_TICKS_P(GR)) dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .axil_req(axil_req),
    .axil_rsp(axil_rsp),
    .low_speed_osc(low_speed_osc),
    .other_reset(other_reset),
    .idle_mode(idle_mode),
    .pdown_mode(pdown_mode),
    .irq_req(irq_req),
    .wake_req(wake_req),
    .sys_reset_req(sys_reset_req)
  );

  // system clock
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  // slow oscillator, period 2*HP clocks
  always @(posedge clk_sys)
  begin
    osc_cnt <= (osc_cnt == HP - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == HP - 1)
      low_speed_osc <= ~low_speed_osc;
  end

  // compare and count
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one register write, response checked
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    axil_req.awvalid <= 1'b1;
    axil_req.awaddr <= a;
    axil_req.wvalid <= 1'b1;
    axil_req.wdata <= {24'h000000, d};
    axil_req.wstrb <= 4'h1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_sys);
      if (!aw_ok && axil_rsp.awready)
      begin
        aw_ok = 1'b1;
        axil_req.awvalid <= 1'b0;
      end
      if (!w_ok && axil_rsp.wready)
      begin
        w_ok = 1'b1;
        axil_req.wvalid <= 1'b0;
      end
    end
    while (axil_rsp.bvalid !== 1'b1)
      @(posedge clk_sys);
    axil_req.bready <= 1'b1;
    @(posedge clk_sys);
    check("bresp", 32'(er), 32'(axil_rsp.bresp));
    axil_req.bready <= 1'b0;
  endtask : wr

  // one register read into rv, response checked
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk_sys);
    axil_req.arvalid <= 1'b1;
    axil_req.araddr <= a;
    do @(posedge clk_sys); while (axil_rsp.arready !== 1'b1);
    axil_req.arvalid <= 1'b0;
    do @(posedge clk_sys); while (axil_rsp.rvalid !== 1'b1);
    axil_req.rready <= 1'b1;
    @(posedge clk_sys);
    rv = axil_rsp.rdata;
    check("rresp", 32'(er), 32'(axil_rsp.rresp));
    axil_req.rready <= 1'b0;
  endtask : rd

  // unlock sequence then protected write
  task automatic ul(input logic [7:0] a, input logic [7:0] d);
    wr(OFS_KEY, KEY_FIRST, RESP_OKAY);
    wr(OFS_KEY, KEY_SECOND, RESP_OKAY);
    wr(a, d, RESP_OKAY);
  endtask : ul

  // wait for irq (0), wake (1) or system reset (2) within lim clocks
  task automatic waitfor(input int sel, input int lim);
    cyc = 0;
    seen = 1'b0;
    while (!seen && cyc < lim)
    begin
      @(posedge clk_sys);
      cyc++;
      seen = (sel == 0) ? irq_req === 1'b1 : (sel == 1) ? wake_req === 1'b1 :
        sys_reset_req === 1'b1;
    end
  endtask : waitfor

  // one short reset pulse other than power-on
  task automatic pulse_other;
    @(posedge clk_sys);
    other_reset <= 1'b1;
    @(posedge clk_sys);
    other_reset <= 1'b0;
  endtask : pulse_other

  // verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, RESP_OKAY);
    check("ctl por", 32'h07, rv);
    rd(OFS_CONFIG, RESP_OKAY);
    check("cfg por", 32'hF0, rv);
    rd(8'h14, RESP_SLVERR);
    wr(8'h20, 8'hFF, RESP_SLVERR);
    wr(OFS_CONTROL, 8'h80, RESP_OKAY);
    rd(OFS_CONTROL, RESP_OKAY);
    check("ctl locked", 32'h07, rv);
    wr(OFS_KEY, KEY_FIRST, RESP_OKAY);
    wr(OFS_KEY, KEY_SECOND, RESP_OKAY);
    rd(OFS_KEY, RESP_OKAY);
    check("key open", 32'h1, rv);
    wr(OFS_COUNT, 8'hFF, RESP_OKAY);
    rd(OFS_KEY, RESP_OKAY);
    check("key closed", 32'h0, rv);
    @(posedge low_speed_osc);
    ul(OFS_CONTROL, 8'h47);
    rd(OFS_CONTROL, RESP_OKAY);
    check("clr pending", 32'h47, rv);
    repeat (2) @(posedge low_speed_osc);
    rd(OFS_CONTROL, RESP_OKAY);
    check("clr done", 32'h07, rv);
    wr(OFS_IRQ_EN, 8'h03, RESP_OKAY);
    // interval for every prescale code, longest first
    for (int c = 7; c >= 0; c--)
    begin
      int r;
      r = (c == 0) ? 1 : (1 << (c + 1));
      ul(OFS_CONTROL, 8'(c));
      @(posedge low_speed_osc);
      ul(OFS_CONTROL, 8'hC0 | 8'(c));
      waitfor(0, (TO * r + 4) * 2 * HP);
      t = (cyc + HP) / (2 * HP);
      check("interval", 1, 32'(seen && t >= TO * r && t <= TO * r + 2));
    end
    for (int e = 0; e < 4; e++)
    begin
      wr(OFS_IRQ_EN, 8'(e), RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      check("irq gate", 32'(e == 3), 32'(irq_req));
    end
    ul(OFS_CONTROL, 8'h80);
    waitfor(0, (TO + 2) * 2 * HP);
    check("rerun", 1, 32'(seen));
    ul(OFS_CONTROL, 8'h00);
    waitfor(0, (2 * TO + 2) * 2 * HP);
    check("halted", 0, 32'(seen));
    rd(OFS_CONTROL, RESP_OKAY);
    check("flag cleared", 32'h00, rv);
    ul(OFS_CONTROL, 8'h90);
    pdown_mode <= 1'b1;
    waitfor(1, (TO + 3) * 2 * HP);
    check("wake sleep run", 1, 32'(seen));
    pdown_mode <= 1'b0;
    ul(OFS_CONTROL, 8'h80);
    pdown_mode <= 1'b1;
    waitfor(1, (2 * TO + 2) * 2 * HP);
    check("sleep stop", 0, 32'(seen));
    pdown_mode <= 1'b0;
    // reset-timer mode
    ul(OFS_CONFIG, 8'h00);
    pulse_other();
    repeat (2) @(posedge low_speed_osc);
    rd(OFS_COUNT, RESP_OKAY);
    check("count runs", 1, 32'(rv != 32'h0));
    waitfor(2, (TO + GR + 4) * 2 * HP);
    check("dog reset", 1, 32'(seen && cyc > (TO + GR - 4) * 2 * HP));
    rd(OFS_CONTROL, RESP_OKAY);
    check("after dog", 32'h28, rv);
    wr(OFS_IRQ_EN, 8'h03, RESP_OKAY);
    ul(OFS_CONTROL, 8'h08);
    waitfor(0, (TO + 3) * 2 * HP);
    check("reset irq", 1, 32'(seen));
    ul(OFS_CONTROL, 8'h48);
    waitfor(2, 10 * 2 * HP);
    check("fed dog", 0, 32'(seen));
    pulse_other();
    rd(OFS_CONTROL, RESP_OKAY);
    check("other rst", 32'h08, rv);
    ul(OFS_CONFIG, 8'h50);
    @(posedge low_speed_osc);
    idle_mode <= 1'b1;
    repeat (3) @(posedge low_speed_osc);
    rd(OFS_COUNT, RESP_OKAY);
    check("idle stop", 32'h0, rv);
    idle_mode <= 1'b0;
    ul(OFS_CONFIG, 8'h00);
    idle_mode <= 1'b1;
    waitfor(1, (TO + 3) * 2 * HP);
    check("idle wake", 1, 32'(seen));
    idle_mode <= 1'b0;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, RESP_OKAY);
    check("por again", 32'h07, rv);
    report_and_stop();
  end

  // hang guard
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
endmodule : wdg_timer_bench
